// ---- maintenance_counters_bench.sv ----
// Purpose: self-checking bench for the maintenance counters and keypad menu
// Assumes: hour shortened to 2000 cycles; keypad model drives the keys
// Notes:   rows are checked just after an hour tick so the counters stand still
`timescale 1ns/1ps
`include "mcnt_map.svh"
`default_nettype none
module maintenance_counters_bench;
  localparam int HC = 2000;
  typedef struct {
    logic [3:0]  item;
    logic [15:0] nv;
    logic [15:0] dig;
    logic [3:0]  dp;
  } mcnt_row_t;
  logic        clk_i;
  logic        rst_n_i;
  logic [4:0]  key;
  logic [1:0]  depth;
  logic        fan_run, run_cmd, cerr, remote, nv_load;
  logic [7:0]  ccode, temp, nv_code, err_code, max_temp;
  logic [15:0] curr, nv_on, nv_cap, nv_fan, nv_st, nv_er;
  logic [1:0]  mode;
  logic [15:0] digits, on_h, cap_h, fan_h, starts, errs, max_curr;
  logic [3:0]  dp;
  int          n_mismatch;
  int          n_compared;
  int          cur;
  mcnt_row_t   rows [15];

  mcnt_keypad mcnt_keypad_i (.clk_i(clk_i), .key_o(key));
  mcnt_top #(.HOUR_CYCLES(39'(HC))) mcnt_top_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .key_i(key), .menu_depth_setting_i(depth),
    .fan_onoff_control_i(1'h1), .fan_running_i(fan_run), .run_cmd_i(run_cmd), .comm_err_i(cerr),
    .comm_err_code_i(ccode), .heatsink_temp_i(temp), .eff_current_i(curr), .dc_bus_volt_i(16'h012C),
    .cap_percent_i(8'h57), .fw_version_i(16'h1A2B), .kp_version_i(16'h0C3D), .remote_kp_i(remote),
    .nv_load_i(nv_load), .nv_on_hours_i(nv_on), .nv_cap_hours_i(nv_cap), .nv_fan_hours_i(nv_fan),
    .nv_starts_i(nv_st), .nv_errs_i(nv_er), .nv_err_code_i(nv_code), .mode_o(mode), .digits_o(digits),
    .dp_o(dp), .on_hours_o(on_h), .cap_hours_o(cap_h), .fan_hours_o(fan_h), .starts_o(starts),
    .errs_o(errs), .err_code_o(err_code), .max_temp_o(max_temp), .max_curr_o(max_curr));

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val
  task automatic chk_disp(input logic [15:0] d, input logic [3:0] p, input string what);
    chk_val(digits, d, what);
    chk_val({12'h000, dp}, {12'h000, p}, what);
  endtask : chk_disp
  task automatic kp(input int unsigned k);
    mcnt_keypad_i.press(k, 6);
  endtask : kp
  // a missing tick is reported rather than hanging the run
  task automatic wait_hour();
    logic [15:0] old;
    int          n;
    old = on_h;
    n = 0;
    while (on_h === old && n < 3 * HC)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_val({15'h0000, n < 3 * HC}, 16'h0001, "hour tick");
  endtask : wait_hour
  task automatic nv_put(input logic [15:0] a, c, f, s, e, input logic [7:0] k);
    @(negedge clk_i);
    {nv_on, nv_cap, nv_fan, nv_st, nv_er, nv_code} = {a, c, f, s, e, k};
    nv_load = 1'b1;
    @(negedge clk_i);
    nv_load = 1'b0;
  endtask : nv_put
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (45 * HC) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    rst_n_i = 1'b0;
    {depth, fan_run, run_cmd, cerr, remote, nv_load} = {2'h2, 5'b00010};
    {ccode, temp, curr} = {8'h00, 8'h2D, 16'h007B};
    {nv_on, nv_cap, nv_fan, nv_st, nv_er, nv_code} = '0;
    rows = '{'{4'h0, 16'h0001, 16'h0001, 4'h8}, '{4'h0, 16'h270F, 16'h9999, 4'h8},
             '{4'h0, 16'h2710, 16'h1000, 4'h4}, '{4'h0, 16'hFFFF, 16'h6553, 4'h4},
             '{4'h1, 16'h0000, 16'h0300, 4'h0}, '{4'h2, 16'h0000, 16'h0045, 4'h0},
             '{4'h3, 16'h0000, 16'h0123, 4'h0}, '{4'h4, 16'h0000, 16'h0087, 4'h0},
             '{4'h5, 16'h2719, 16'h1000, 4'h4}, '{4'h6, 16'h04D2, 16'h1234, 4'h8},
             '{4'h7, 16'h2723, 16'h1001, 4'h4}, '{4'h8, 16'h002A, 16'h0042, 4'h0},
             '{4'h9, 16'h00C8, 16'h0200, 4'h0}, '{4'hA, 16'h0000, 16'h1A2B, 4'h0},
             '{4'hB, 16'h0000, 16'h0C3D, 4'h0}};
    repeat (4) @(negedge clk_i);
    chk_val({14'h0000, mode}, 16'h0000, "mode in reset");
    rst_n_i = 1'b1;
    kp(`MCNT_KEY_PROG);
    chk_val({14'h0000, mode}, 16'h0001, "prog to menu");
    chk_disp(16'h0000, 4'h0, "menu 0");
    mcnt_keypad_i.press(`MCNT_KEY_UP, 20);
    chk_disp(16'h0001, 4'h0, "long hold one step");
    repeat (4) kp(`MCNT_KEY_UP);
    kp(`MCNT_KEY_FUNC);
    chk_val({14'h0000, mode}, 16'h0002, "menu 5 to list");
    chk_disp(16'h5B00, 4'h0, "list item 0");
    $display("test menu entry done");
    wait_hour();
    cur = 0;
    foreach (rows[i])
    begin
      while (cur < rows[i].item)
      begin
        kp(`MCNT_KEY_UP);
        cur++;
      end
      wait_hour();
      nv_put(rows[i].nv, rows[i].nv, rows[i].nv, rows[i].nv, rows[i].nv, rows[i].nv[7:0]);
      kp(`MCNT_KEY_FUNC);
      chk_val({14'h0000, mode}, 16'h0003, "item data");
      chk_disp(rows[i].dig, rows[i].dp, "item value");
      kp(`MCNT_KEY_RET);
      chk_val({14'h0000, mode}, 16'h0002, "back to list");
    end
    $display("test item table done");
    remote = 1'b0;
    kp(`MCNT_KEY_DOWN);
    chk_disp(16'h5B14, 4'h0, "list item 10");
    kp(`MCNT_KEY_UP);
    chk_disp(16'h5B00, 4'h0, "keypad item skipped");
    kp(`MCNT_KEY_RET);
    chk_disp(16'h0005, 4'h0, "second return to menu");
    depth = 2'h1;
    kp(`MCNT_KEY_FUNC);
    chk_val({14'h0000, mode}, 16'h0001, "short menu refuses");
    depth = 2'h2;
    kp(`MCNT_KEY_PROG);
    $display("test navigation done");
    wait_hour();
    nv_put(16'hFFFF, 16'hFFFF, 16'hFFFE, 16'hFFFF, 16'h270F, 8'h00);
    fan_run = 1'b1;
    wait_hour();
    chk_val(on_h, 16'h0000, "hours wrap");
    chk_val(cap_h, 16'hFFFF, "cap hours hold");
    repeat (2 * HC + 10) @(negedge clk_i);
    chk_val(fan_h, 16'hFFFF, "fan hours hold");
    fan_run = 1'b0;
    nv_put(16'h0000, 16'h0000, 16'h0005, 16'hFFFF, 16'h270F, 8'h00);
    wait_hour();
    wait_hour();
    chk_val(fan_h, 16'h0005, "fan stopped");
    run_cmd = 1'b1;
    repeat (2) @(negedge clk_i);
    run_cmd = 1'b0;
    chk_val(starts, 16'h0001, "starts wrap");
    {cerr, ccode} = {1'b1, 8'h07};
    @(negedge clk_i);
    cerr = 1'b0;
    chk_val(errs, 16'h0000, "errors wrap");
    chk_val({8'h00, err_code}, 16'h0007, "error code");
    {cerr, ccode} = {1'b1, 8'h21};
    @(negedge clk_i);
    cerr = 1'b0;
    chk_val(errs, 16'h0001, "errors count");
    chk_val({8'h00, err_code}, 16'h0021, "latest code");
    $display("test counters done");
    wait_hour();
    {temp, curr} = {8'h5A, 16'h01F4};
    @(negedge clk_i);
    {temp, curr} = {8'h2D, 16'h007B};
    wait_hour();
    chk_val({8'h00, max_temp}, 16'h005A, "hour max temp");
    chk_val(max_curr, 16'h01F4, "hour max current");
    wait_hour();
    chk_val({8'h00, max_temp}, 16'h002D, "next hour temp");
    chk_val(max_curr, 16'h007B, "next hour current");
    $display("test maxima done");
    rst_n_i = 1'b0;
    @(negedge clk_i);
    chk_val({mode, starts[13:0]}, 16'h0000, "mid-run reset");
    rst_n_i = 1'b1;
    nv_put(16'h0123, 16'h0456, 16'h0789, 16'h0AB0, 16'h0011, 8'h45);
    chk_val(on_h ^ cap_h ^ fan_h, 16'h02FC, "restored hours");
    chk_val(on_h, 16'h0123, "restored on hours");
    chk_val(cap_h, 16'h0456, "restored cap hours");
    chk_val(fan_h, 16'h0789, "restored fan hours");
    chk_val(starts, 16'h0AB0, "restored starts");
    chk_val({errs[7:0], err_code}, 16'h1145, "restored errors");
    $display("test reset restore done");
    close_out();
  end
endmodule : maintenance_counters_bench
`default_nettype wire

// ---- mcnt_bcd.sv ----
// Purpose: turns a display value into four display nibbles
// Assumes: decimal values are clamped to 9999
// Notes:   hex mode passes nibbles through for menu and item codes and versions
`timescale 1ns/1ps
`include "mcnt_map.svh"
`default_nettype none
module mcnt_bcd (
  input  wire logic [15:0] bin_i,
  input  wire logic        hex_i,
  output logic      [15:0] digits_o
);
  function automatic logic [15:0] to_bcd(input logic [15:0] v);
    logic [31:0] sh;
    sh = {16'h0000, v};
    for (int i = 0; i < 16; i++)
    begin
      for (int d = 0; d < 4; d++)
      begin
        if (sh[16 + 4 * d +: 4] > 4'h4)
        begin
          sh[16 + 4 * d +: 4] = sh[16 + 4 * d +: 4] + 4'h3;
        end
      end
      sh = {sh[30:0], 1'b0};
    end
    return sh[31:16];
  endfunction : to_bcd

  logic [15:0] clamped;

  assign clamped  = (bin_i > `MCNT_DISP_MAX) ? `MCNT_DISP_MAX : bin_i;
  assign digits_o = hex_i ? bin_i : to_bcd(clamped);
endmodule : mcnt_bcd
`default_nettype wire

// ---- mcnt_keypad.sv ----
// Purpose: operator keypad model that presses and releases single keys
// Assumes: keys change just after the falling clock edge
// Notes:   a long hold must still count as one press, so holds are caller-chosen
`timescale 1ns/1ps
`default_nettype none
module mcnt_keypad (
  input  wire logic       clk_i,
  output logic      [4:0] key_o
);
  initial key_o = 5'h00;
  // release lasts 4 cycles so the 3-stage filter sees the key drop before the next press
  task automatic press(input int unsigned k, input int unsigned hold);
    @(negedge clk_i);
    key_o[k] = 1'b1;
    repeat (hold) @(negedge clk_i);
    key_o[k] = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : press
endmodule : mcnt_keypad
`default_nettype wire

// ---- mcnt_map.svh ----
// Purpose: constants for the maintenance counters and keypad menu
// Assumes: 100 MHz clock, one keypad display of four digits
// Notes:   every count and code used by more than one place lives here
`ifndef MCNT_MAP_SVH
`define MCNT_MAP_SVH
`define MCNT_CLK_MHZ     64'd100
`define MCNT_HOUR_S      64'd3600
`define MCNT_HOUR_CYC    (`MCNT_HOUR_S * `MCNT_CLK_MHZ * 64'd1000000)
`define MCNT_MENU_FULL   2'h2
`define MCNT_MENU_MAINT  3'h5
`define MCNT_MENU_LAST   3'h6
`define MCNT_ITEM_LAST   4'hB
`define MCNT_ITEM_KPAD   4'hB
`define MCNT_CNT_MAX     16'hFFFF
`define MCNT_ERR_MAX     16'h270F
`define MCNT_HOUR_SPLIT  16'h2710
`define MCNT_DISP_MAX    16'h270F
`define MCNT_DP_THOU     4'h8
`define MCNT_DP_HUND     4'h4
`define MCNT_DP_NONE     4'h0
`define MCNT_DIG_DASH    4'hB
`define MCNT_DIG_MENU    4'h5
`define MCNT_KEY_PROG    0
`define MCNT_KEY_UP      1
`define MCNT_KEY_DOWN    2
`define MCNT_KEY_FUNC    3
`define MCNT_KEY_RET     4
`define MCNT_KEYS        5
`endif

// ---- mcnt_pkg.sv ----
// Purpose: shared types of the maintenance counters
// Assumes: constants come from mcnt_map.svh
// Notes:   state order sets the mode_o codes and makes ST_RUN the reset state; no codes given
`default_nettype none
package mcnt_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_MENU,
    ST_LIST,
    ST_DATA
  } mcnt_state_t;
endpackage : mcnt_pkg
`default_nettype wire

// ---- mcnt_top.sv ----
// Purpose: maintenance counters, hourly maxima and keypad menu
// Assumes: keys come from the keypad pins; other inputs share clk_i
// Notes:   counter outputs are the image saved at power-down
`timescale 1ns/1ps
`include "mcnt_map.svh"
`default_nettype none
module mcnt_top #(
  parameter logic [38:0] HOUR_CYCLES = 39'(`MCNT_HOUR_CYC)
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  key_i,
  input  wire logic [1:0]  menu_depth_setting_i,
  input  wire logic        fan_onoff_control_i,
  input  wire logic        fan_running_i,
  input  wire logic        run_cmd_i,
  input  wire logic        comm_err_i,
  input  wire logic [7:0]  comm_err_code_i,
  input  wire logic [7:0]  heatsink_temp_i,
  input  wire logic [15:0] eff_current_i,
  input  wire logic [15:0] dc_bus_volt_i,
  input  wire logic [7:0]  cap_percent_i,
  input  wire logic [15:0] fw_version_i,
  input  wire logic [15:0] kp_version_i,
  input  wire logic        remote_kp_i,
  input  wire logic        nv_load_i,
  input  wire logic [15:0] nv_on_hours_i,
  input  wire logic [15:0] nv_cap_hours_i,
  input  wire logic [15:0] nv_fan_hours_i,
  input  wire logic [15:0] nv_starts_i,
  input  wire logic [15:0] nv_errs_i,
  input  wire logic [7:0]  nv_err_code_i,
  output logic      [1:0]  mode_o,
  output logic      [15:0] digits_o,
  output logic      [3:0]  dp_o,
  output logic      [15:0] on_hours_o,
  output logic      [15:0] cap_hours_o,
  output logic      [15:0] fan_hours_o,
  output logic      [15:0] starts_o,
  output logic      [15:0] errs_o,
  output logic      [7:0]  err_code_o,
  output logic      [7:0]  max_temp_o,
  output logic      [15:0] max_curr_o
);
  typedef struct packed {
    mcnt_pkg::mcnt_state_t st;
    logic [2:0]            menu;
    logic [3:0]            item;
    logic [4:0]            ks1;
    logic [4:0]            ks2;
    logic [4:0]            ks3;
    logic [4:0]            kst;
    logic [38:0]           hcnt;
    logic [38:0]           fcnt;
    logic [15:0]           poh;
    logic [15:0]           cap;
    logic [15:0]           fan;
    logic [15:0]           starts;
    logic [15:0]           errs;
    logic [7:0]            ecode;
    logic [7:0]            tmax_run;
    logic [7:0]            tmax;
    logic [15:0]           imax_run;
    logic [15:0]           imax;
    logic [15:0]           dig;
    logic [3:0]            dp;
  } mcnt_reg_t;

  mcnt_reg_t   s_r;
  mcnt_reg_t   s_nxt;
  logic [4:0]  press;
  logic        hour_en;
  logic        fan_en;
  logic [20:0] sel;
  logic [15:0] bcd_dig;

  // hours and startups share one scaling: d.ddd, then dd.dd
  function automatic logic [19:0] scale(input logic [15:0] v);
    if (v < `MCNT_HOUR_SPLIT)
    begin
      return {`MCNT_DP_THOU, v};
    end
    return {`MCNT_DP_HUND, 16'(v / 16'd10)};
  endfunction : scale

  function automatic logic [7:0] item_code(input logic [3:0] idx);
    case (idx)
      4'h0:    item_code = 8'h00;
      4'h1:    item_code = 8'h01;
      4'h2:    item_code = 8'h03;
      4'h3:    item_code = 8'h04;
      4'h4:    item_code = 8'h05;
      4'h5:    item_code = 8'h06;
      4'h6:    item_code = 8'h07;
      4'h7:    item_code = 8'h08;
      4'h8:    item_code = 8'h11;
      4'h9:    item_code = 8'h12;
      4'hA:    item_code = 8'h14;
      default: item_code = 8'h15;
    endcase
  endfunction : item_code

  // returns {hex, dp, value} for what the keypad is to show
  function automatic logic [20:0] disp_sel(input mcnt_reg_t s,
                                           input logic [15:0] volt,
                                           input logic [7:0]  pct,
                                           input logic [15:0] fw,
                                           input logic [15:0] kp);
    case (s.st)
      mcnt_pkg::ST_RUN:  disp_sel = {1'b0, `MCNT_DP_NONE, s.poh};
      mcnt_pkg::ST_MENU: disp_sel = {1'b1, `MCNT_DP_NONE, 13'h0000, s.menu};
      mcnt_pkg::ST_LIST: disp_sel = {1'b1, `MCNT_DP_NONE, `MCNT_DIG_MENU, `MCNT_DIG_DASH, item_code(s.item)};
      mcnt_pkg::ST_DATA:
      begin
        case (s.item)
          4'h0:    disp_sel = {1'b0, scale(s.poh)};
          4'h1:    disp_sel = {1'b0, `MCNT_DP_NONE, volt};
          4'h2:    disp_sel = {1'b0, `MCNT_DP_NONE, 8'h00, s.tmax};
          4'h3:    disp_sel = {1'b0, `MCNT_DP_NONE, s.imax};
          4'h4:    disp_sel = {1'b0, `MCNT_DP_NONE, 8'h00, pct};
          4'h5:    disp_sel = {1'b0, scale(s.cap)};
          4'h6:    disp_sel = {1'b0, scale(s.fan)};
          4'h7:    disp_sel = {1'b0, scale(s.starts)};
          4'h8:    disp_sel = {1'b0, `MCNT_DP_NONE, s.errs};
          4'h9:    disp_sel = {1'b0, `MCNT_DP_NONE, 8'h00, s.ecode};
          4'hA:    disp_sel = {1'b1, `MCNT_DP_NONE, fw};
          default: disp_sel = {1'b1, `MCNT_DP_NONE, kp};
        endcase
      end
      default: disp_sel = {1'b0, `MCNT_DP_NONE, 16'h0000};
    endcase
  endfunction : disp_sel

  function automatic logic [15:0] umax(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction : umax

  function automatic logic [7:0] umax8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction : umax8

  // a press counts once the second and third stage agree on high
  assign press   = s_r.ks2 & s_r.ks3 & ~s_r.kst;
  assign hour_en = (s_r.hcnt == HOUR_CYCLES - 39'd1);
  assign fan_en  = fan_running_i && (s_r.fcnt == HOUR_CYCLES - 39'd1);
  assign sel     = disp_sel(s_r, dc_bus_volt_i, cap_percent_i, fw_version_i, kp_version_i);

  mcnt_bcd u_bcd (
    .bin_i    (sel[15:0]),
    .hex_i    (sel[20]),
    .digits_o (bcd_dig)
  );

  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.ks1 = key_i;
    s_nxt.ks2 = s_r.ks1;
    s_nxt.ks3 = s_r.ks2;
    s_nxt.kst = (s_r.ks2 & s_r.ks3) | (s_r.kst & (s_r.ks2 | s_r.ks3));
    s_nxt.hcnt = hour_en ? 39'd0 : s_r.hcnt + 39'd1;
    // fan time only runs with the fan, whatever on/off control does
    if (fan_running_i)
    begin
      s_nxt.fcnt = fan_en ? 39'd0 : s_r.fcnt + 39'd1;
    end
    if (hour_en)
    begin
      s_nxt.poh = s_r.poh + 16'h0001;
      if (s_r.cap != `MCNT_CNT_MAX)
      begin
        s_nxt.cap = s_r.cap + 16'h0001;
      end
      s_nxt.tmax     = umax8(s_r.tmax_run, heatsink_temp_i);
      s_nxt.tmax_run = heatsink_temp_i;
      s_nxt.imax     = umax(s_r.imax_run, eff_current_i);
      s_nxt.imax_run = eff_current_i;
    end
    else
    begin
      s_nxt.tmax_run = umax8(s_r.tmax_run, heatsink_temp_i);
      s_nxt.imax_run = umax(s_r.imax_run, eff_current_i);
    end
    if (fan_en && s_r.fan != `MCNT_CNT_MAX)
    begin
      s_nxt.fan = s_r.fan + 16'h0001;
    end
    if (run_cmd_i)
    begin
      s_nxt.starts = s_r.starts + 16'h0001;
    end
    if (comm_err_i)
    begin
      s_nxt.errs  = (s_r.errs >= `MCNT_ERR_MAX) ? 16'h0000 : s_r.errs + 16'h0001;
      s_nxt.ecode = comm_err_code_i;
    end
    // reload wins over a same-cycle count; the image is restored on every cycle that nv_load_i is high
    if (nv_load_i)
    begin
      s_nxt.poh    = nv_on_hours_i;
      s_nxt.cap    = nv_cap_hours_i;
      s_nxt.fan    = nv_fan_hours_i;
      s_nxt.starts = nv_starts_i;
      s_nxt.errs   = nv_errs_i;
      s_nxt.ecode  = nv_err_code_i;
    end
    case (s_r.st)
      mcnt_pkg::ST_RUN:
      begin
        if (press[`MCNT_KEY_PROG])
        begin
          s_nxt.st = mcnt_pkg::ST_MENU;
        end
      end
      mcnt_pkg::ST_MENU:
      begin
        if (press[`MCNT_KEY_PROG])
        begin
          s_nxt.st = mcnt_pkg::ST_RUN;
        end
        else if (press[`MCNT_KEY_UP])
        begin
          s_nxt.menu = (s_r.menu == `MCNT_MENU_LAST) ? 3'h0 : s_r.menu + 3'h1;
        end
        else if (press[`MCNT_KEY_DOWN])
        begin
          s_nxt.menu = (s_r.menu == 3'h0) ? `MCNT_MENU_LAST : s_r.menu - 3'h1;
        end
        else if (press[`MCNT_KEY_FUNC] && s_r.menu == `MCNT_MENU_MAINT &&
                 menu_depth_setting_i == `MCNT_MENU_FULL)
        begin
          s_nxt.st   = mcnt_pkg::ST_LIST;
          s_nxt.item = 4'h0;
        end
      end
      mcnt_pkg::ST_LIST:
      begin
        if (press[`MCNT_KEY_RET])
        begin
          s_nxt.st = mcnt_pkg::ST_MENU;
        end
        else if (press[`MCNT_KEY_FUNC])
        begin
          s_nxt.st = mcnt_pkg::ST_DATA;
        end
        else if (press[`MCNT_KEY_UP])
        begin
          // keypad version is skipped unless a remote keypad is active
          if (s_r.item >= `MCNT_ITEM_LAST || (!remote_kp_i && s_r.item == `MCNT_ITEM_KPAD - 4'h1))
          begin
            s_nxt.item = 4'h0;
          end
          else
          begin
            s_nxt.item = s_r.item + 4'h1;
          end
        end
        else if (press[`MCNT_KEY_DOWN])
        begin
          if (s_r.item == 4'h0)
          begin
            s_nxt.item = remote_kp_i ? `MCNT_ITEM_LAST : `MCNT_ITEM_KPAD - 4'h1;
          end
          else
          begin
            s_nxt.item = s_r.item - 4'h1;
          end
        end
      end
      mcnt_pkg::ST_DATA:
      begin
        if (press[`MCNT_KEY_RET])
        begin
          s_nxt.st = mcnt_pkg::ST_LIST;
        end
      end
      default: s_nxt.st = mcnt_pkg::ST_RUN;
    endcase
    s_nxt.dig = bcd_dig;
    s_nxt.dp  = sel[19:16];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign mode_o      = s_r.st;
  assign digits_o    = s_r.dig;
  assign dp_o        = s_r.dp;
  assign on_hours_o  = s_r.poh;
  assign cap_hours_o = s_r.cap;
  assign fan_hours_o = s_r.fan;
  assign starts_o    = s_r.starts;
  assign errs_o      = s_r.errs;
  assign err_code_o  = s_r.ecode;
  assign max_temp_o  = s_r.tmax;
  assign max_curr_o  = s_r.imax;

  a_menu_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_r.st == mcnt_pkg::ST_MENU && menu_depth_setting_i != `MCNT_MENU_FULL) |=> s_r.st != mcnt_pkg::ST_LIST)
    else $error("maintenance list entered outside full-menu depth");

  a_run_prog: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_r.st == mcnt_pkg::ST_RUN && press[`MCNT_KEY_PROG]) |=> s_r.st == mcnt_pkg::ST_MENU)
    else $error("program key did not open the menu");

  a_data_return: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_r.st == mcnt_pkg::ST_DATA && press[`MCNT_KEY_RET]) |=> s_r.st == mcnt_pkg::ST_LIST)
    else $error("return from data did not reach the list");

  a_hour_scale: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_r.st == mcnt_pkg::ST_DATA && s_r.item == 4'h0 && s_r.poh >= `MCNT_HOUR_SPLIT) |=> dp_o == `MCNT_DP_HUND)
    else $error("large hour count not shown in tens");

  a_on_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (hour_en && on_hours_o == `MCNT_CNT_MAX && !nv_load_i) |=> on_hours_o == 16'h0000)
    else $error("power-on hours did not wrap");

  a_cap_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cap_hours_o == `MCNT_CNT_MAX && !nv_load_i) |=> cap_hours_o == `MCNT_CNT_MAX)
    else $error("capacitor hours left saturation");

  a_fan_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!fan_running_i && !nv_load_i) |=> $stable(fan_hours_o))
    else $error("fan hours moved with the fan stopped");

  a_start_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (run_cmd_i && !nv_load_i) |=> starts_o == 16'($past(starts_o) + 16'h0001))
    else $error("startup count did not step by one");

  a_err_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (comm_err_i && errs_o == `MCNT_ERR_MAX && !nv_load_i) |=> errs_o == 16'h0000)
    else $error("error count did not wrap past 9999");

  a_err_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (comm_err_i && !nv_load_i) |=> err_code_o == $past(comm_err_code_i))
    else $error("latest error code not kept");
endmodule : mcnt_top
`default_nettype wire
